// >>> src/opl_loop_top.sv
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/10ps
module opl_loop_top
  import opl_pkg::*;
#(
  parameter int unsigned AW = 12
)(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [AW-1:0]         s_axi_awaddr,
  input  wire logic [2:0]            s_axi_awprot,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [AW-1:0]         s_axi_araddr,
  input  wire logic [2:0]            s_axi_arprot,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic [NCH-1:0]        color_on_input,
  input  wire logic [NCH-1:0]        sense_below,
  input  wire logic [NCH-1:0]        sense_above,
  output logic [NCH-1:0][11:0]       channel_drive_current,
  output logic [NCH-1:0][12:0]       target_code,
  output logic [1:0]                 tia_filter_select,
  output logic [1:0]                 clock_source_select,
  output logic [3:0]                 osc_control,
  output logic                       ext_timing_clock_en,
  output logic                       timing_tick
);
  typedef struct packed {
    opl_phase_e      ph;
    logic [7:0]      icnt;
    logic [7:0]      tcnt;
    logic [3:0]      dcnt;
    logic [1:0][1:0] pipe;
    logic [7:0]      dec;
    logic [1:0]      dpol;
    logic [11:0]     gain;
    logic [12:0]     tgt;
    logic [1:0]      sel;
  } opl_ch_s;

  typedef struct packed {
    logic [NREG-1:0][7:0] regs;
    logic                 aw_v;
    logic                 aw_ok;
    logic [7:0]           aw_i;
    logic                 w_v;
    logic [7:0]           w_d;
    logic                 w_s;
    logic                 b_v;
    logic                 b_e;
    logic                 r_v;
    logic                 r_e;
    logic [31:0]          r_d;
    logic [NCH-1:0]       on_p;
    opl_ch_s [NCH-1:0]    ch;
  } opl_top_s;

  opl_top_s q;
  opl_top_s d;

  if (AW < 10) begin : g_chk
    $error("opl_loop_top: AW must be at least 10");
  end

  function automatic logic [5:0] slot(input logic [7:0] i);
    logic [7:0] s;
    s = i - IDX_FIRST;
    return s[5:0];
  endfunction

  function automatic logic [7:0] rget(input logic [NREG-1:0][7:0] r, input logic [7:0] i);
    return r[slot(i)];
  endfunction

  function automatic logic rw_hit(input logic [7:0] i);
    return i >= IDX_FIRST && i <= IDX_LAST && i != IDX_HOLE_A && i != IDX_HOLE_B;
  endfunction

  function automatic logic [7:0] ph_len(input opl_phase_e p, input logic [7:0] c);
    unique case (p)
      PH_ONE:   return LEN1_TAB[c[LEN1_LSB +: 2]];
      PH_TWO:   return LEN23_TAB[c[LEN2_LSB +: 2]];
      PH_THREE: return LEN23_TAB[c[LEN3_LSB +: 2]];
      default:  return 8'h00;
    endcase
  endfunction

  // Skips intervals programmed to zero length
  function automatic opl_phase_e ph_next(input opl_phase_e p, input logic [7:0] c);
    opl_phase_e n;
    n = p;
    for (int k = 0; k < 3; k++) begin
      if (n != PH_FOUR && (k == 0 || ph_len(n, c) == 8'h00)) begin
        n = (n == PH_ONE) ? PH_TWO : (n == PH_TWO) ? PH_THREE : PH_FOUR;
      end
    end
    return n;
  endfunction

  function automatic logic [11:0] sat_step(input logic [11:0] g, input logic [3:0] s, input logic up);
    logic [12:0] t;
    t = up ? {1'b0, g} + {9'h000, s} : {1'b0, g} - {9'h000, s};
    if (t[12]) return up ? 12'hfff : 12'h000;
    return t[11:0];
  endfunction

  logic [3*NCH-1:0] sy;
  logic [NCH-1:0]   on_s;
  logic [NCH-1:0]   pb;
  logic [NCH-1:0]   pa;
  logic             lt;
  logic             t16;
  logic             multi;
  logic [7:0]       gbl;

  // Comparator and color-on pins are asynchronous to aclk
  opl_sync #(.W(3*NCH)) u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in ({sense_above, sense_below, color_on_input}),
    .sync_out (sy)
  );

  assign on_s = sy[NCH-1:0];
  assign pb   = sy[2*NCH-1:NCH];
  assign pa   = sy[3*NCH-1:2*NCH];

  opl_tick_div #(.W(2)) u_loop_div (
    .aclk    (aclk),
    .aresetn (aresetn),
    .in_tick (1'b1),
    .limit   (2'(LOOP_DIV - 1)),
    .tick    (lt)
  );

  opl_tick_div #(.W(4)) u_pre16 (
    .aclk    (aclk),
    .aresetn (aresetn),
    .in_tick (1'b1),
    .limit   (4'(TIMING_PRESCALE - 1)),
    .tick    (t16)
  );

  opl_tick_div #(.W(11)) u_tdiv (
    .aclk    (aclk),
    .aresetn (aresetn),
    .in_tick (t16),
    .limit   (TDIV_TAB[q.regs[slot(IDX_CLK_DIVIDER)][TDIV_LSB +: 3]]),
    .tick    (timing_tick)
  );

  assign gbl   = rget(q.regs, IDX_LOOP_GLOBAL_CONTROL);
  assign multi = (on_s[0] & on_s[1]) | (on_s[0] & on_s[2]) | (on_s[1] & on_s[2]);

  assign s_axi_awready = !q.aw_v && !q.b_v;
  assign s_axi_wready  = !q.w_v && !q.b_v;
  assign s_axi_bvalid  = q.b_v;
  assign s_axi_bresp   = q.b_e ? RESP_SLVERR : RESP_OKAY;
  assign s_axi_arready = !q.r_v;
  assign s_axi_rvalid  = q.r_v;
  assign s_axi_rdata   = q.r_d;
  assign s_axi_rresp   = q.r_e ? RESP_SLVERR : RESP_OKAY;

  always_comb begin
    logic [7:0]  sr;
    logic [7:0]  pr;
    logic [7:0]  ir;
    logic [7:0]  ai;
    logic [7:0]  si;
    logic [8:0]  nd;
    logic [3:0]  step;
    logic [1:0]  pol;
    logic [1:0]  ps;
    logic        rise;
    logic        fall;
    logic        off;
    logic        ctk;
    logic        mis;
    logic        apply;
    sr = '0;
    pr = '0;
    ir = '0;
    nd = '0;
    step = 4'h1;
    pol = '0;
    ps = '0;
    rise = 1'b0;
    fall = 1'b0;
    off = 1'b0;
    ctk = 1'b0;
    mis = 1'b0;
    apply = 1'b0;
    d = q;
    ai = s_axi_araddr[9:2];
    si = ai - IDX_STATUS_CH0;
    if (s_axi_awready && s_axi_awvalid) begin
      d.aw_v  = 1'b1;
      d.aw_i  = s_axi_awaddr[9:2];
      d.aw_ok = (s_axi_awaddr >> 10) == '0;
    end
    if (s_axi_wready && s_axi_wvalid) begin
      d.w_v = 1'b1;
      d.w_d = s_axi_wdata[7:0];
      d.w_s = s_axi_wstrb[0];
    end
    // Address and data may land in either order
    if (q.aw_v && q.w_v) begin
      d.aw_v = 1'b0;
      d.w_v  = 1'b0;
      d.b_v  = 1'b1;
      d.b_e  = !(q.aw_ok && rw_hit(q.aw_i));
      if (q.aw_ok && rw_hit(q.aw_i) && q.w_s) d.regs[slot(q.aw_i)] = q.w_d;
    end
    if (q.b_v && s_axi_bready) d.b_v = 1'b0;
    if (q.r_v && s_axi_rready) d.r_v = 1'b0;
    if (s_axi_arready && s_axi_arvalid) begin
      d.r_v = 1'b1;
      d.r_e = 1'b0;
      d.r_d = '0;
      if ((s_axi_araddr >> 10) != '0) d.r_e = 1'b1;
      else if (rw_hit(ai)) d.r_d = {24'h000000, rget(q.regs, ai)};
      else if (si < 8'(NCH)) d.r_d = {16'h0000, q.on_p[si[1:0]], q.ch[si[1:0]].ph, q.ch[si[1:0]].gain};
      else d.r_e = 1'b1;
    end

    for (int i = 0; i < NCH; i++) begin
      sr = rget(q.regs, IDX_SEL[i]);
      pr = rget(q.regs, IDX_STEP[i]);
      ir = rget(q.regs, IDX_INTV[i]);
      rise = on_s[i] && !q.on_p[i];
      fall = !on_s[i] && q.on_p[i];
      off = sr[SEL_PD_LSB +: 2] == PD_OFF;
      ctk = 1'b0;
      apply = 1'b0;
      ps = q.ch[i].sel;
      pol = q.ch[i].pipe[1];
      mis = pol == 2'b01 || pol == 2'b10;
      nd = 9'h001 << sr[SEL_DEC_LSB +: 3];
      unique case (q.ch[i].ph)
        PH_ONE:  step = 4'h1 << pr[STEP1_LSB +: 2];
        PH_TWO:  step = 4'h1 << pr[STEP2_LSB +: 2];
        default: step = 4'h1;
      endcase
      if (rise) begin
        d.ch[i].ph   = (ph_len(PH_ONE, ir) != 8'h00) ? PH_ONE : ph_next(PH_ONE, ir);
        d.ch[i].icnt = '0;
        d.ch[i].tcnt = '0;
        d.ch[i].dcnt = '0;
        d.ch[i].pipe = '0;
        d.ch[i].dec  = '0;
        d.ch[i].tgt  = {q.regs[slot(IDX_TGT_HI[i])][4:0], rget(q.regs, IDX_TGT_LO[i])};
        d.ch[i].sel  = sr[SEL_PD_LSB +: 2];
      end else if (fall) begin
        d.ch[i].ph = PH_IDLE;
      end else if (lt && q.ch[i].ph != PH_IDLE) begin
        if (q.ch[i].tcnt != 8'hff) d.ch[i].tcnt = q.ch[i].tcnt + 8'h01;
        // Division may kick in mid-interval
        if (q.ch[i].tcnt < DSTART_TAB[ir[DSTART_LSB +: 2]] || q.ch[i].dcnt >= DIVF_TAB[pr[DIVF_LSB +: 2]]) begin
          ctk = 1'b1;
          d.ch[i].dcnt = '0;
        end else begin
          d.ch[i].dcnt = q.ch[i].dcnt + 4'h1;
        end
        if (ctk) begin
          d.ch[i].pipe[0] = {pb[ps], pa[ps]};
          d.ch[i].pipe[1] = q.ch[i].pipe[0];
          if (!mis) begin
            d.ch[i].dec = '0;
          end else if (sr[SEL_DEC_LSB +: 3] == 3'h0) begin
            apply = 1'b1;
          end else if (pol != q.ch[i].dpol || q.ch[i].dec == 8'h00) begin
            d.ch[i].dec  = 8'h01;
            d.ch[i].dpol = pol;
          end else if ({1'b0, q.ch[i].dec} + 9'h001 >= nd) begin
            apply = 1'b1;
            d.ch[i].dec = '0;
          end else begin
            d.ch[i].dec = q.ch[i].dec + 8'h01;
          end
          if (q.ch[i].ph != PH_FOUR) begin
            if ({1'b0, q.ch[i].icnt} + 9'h001 >= {1'b0, ph_len(q.ch[i].ph, ir)}) begin
              d.ch[i].ph   = ph_next(q.ch[i].ph, ir);
              d.ch[i].icnt = '0;
            end else begin
              d.ch[i].icnt = q.ch[i].icnt + 8'h01;
            end
          end
        end
      end
      if (off) begin
        d.ch[i].gain = {q.regs[slot(IDX_MAN_HI[i])][3:0], rget(q.regs, IDX_MAN_LO[i])};
      end else if (apply && !multi && !gbl[i]) begin
        // Below target raises the code; a zero target means dark
        d.ch[i].gain = (q.ch[i].tgt == 13'h0000) ? 12'h000 : sat_step(q.ch[i].gain, step, pol[1]);
      end
    end
    d.on_p = on_s;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.regs <= {NREG{REG_RESET}};
    end else begin
      q <= d;
    end
  end

  for (genvar g = 0; g < NCH; g++) begin : g_out
    assign channel_drive_current[g] = q.ch[g].gain;
    assign target_code[g] = q.ch[g].tgt;
  end

  assign tia_filter_select   = q.regs[slot(IDX_TIA_FILTER)][1:0];
  assign clock_source_select = q.regs[slot(IDX_CLOCK_SOURCE)][1:0];
  assign osc_control         = q.regs[slot(IDX_OSC_CONTROL)][3:0];
  assign ext_timing_clock_en = gbl[EXT_CLK_BIT];

  logic        off0;
  logic [11:0] man0;
  logic [12:0] treg0;
  logic [7:0]  step0;
  logic [7:0]  intv0;
  assign off0  = q.regs[slot(IDX_SEL[0])][SEL_PD_LSB +: 2] == PD_OFF;
  assign man0  = {q.regs[slot(IDX_MAN_HI[0])][3:0], rget(q.regs, IDX_MAN_LO[0])};
  assign treg0 = {q.regs[slot(IDX_TGT_HI[0])][4:0], rget(q.regs, IDX_TGT_LO[0])};
  assign step0 = rget(q.regs, IDX_STEP[0]);
  assign intv0 = rget(q.regs, IDX_INTV[0]);

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_LOOP_DIV3: assert property (lt |=> !lt ##1 !lt ##1 lt)
    else $error("loop tick not every third cycle");
  AST_FIRST_INT: assert property ($rose(on_s[0]) && intv0[7:6] != 2'b00 |=> q.ch[0].ph == PH_ONE)
    else $error("first interval not entered on rise");
  AST_RESTART: assert property ($rose(on_s[0]) |=> q.ch[0].icnt == 8'h00 && q.ch[0].tcnt == 8'h00)
    else $error("sequencer not restarted on rise");
  AST_STOP: assert property ($fell(on_s[0]) |=> q.ch[0].ph == PH_IDLE)
    else $error("sequencer still running after fall");
  AST_TGT_LATCH: assert property ($rose(on_s[0]) |=> q.ch[0].tgt == $past(treg0))
    else $error("target not latched on rise");
  AST_FREEZE: assert property (multi && !off0 |=> $stable(q.ch[0].gain))
    else $error("gain moved while two colors on");
  AST_MANUAL: assert property (off0 |=> q.ch[0].gain == $past(man0))
    else $error("disabled loop not following manual gain");
  AST_ONE_LSB: assert property ((q.ch[0].ph == PH_THREE || q.ch[0].ph == PH_FOUR) && !off0
    && q.ch[0].tgt != 13'h0000 && d.ch[0].gain != q.ch[0].gain
    |-> d.ch[0].gain == q.ch[0].gain + 12'h001 || d.ch[0].gain + 12'h001 == q.ch[0].gain)
    else $error("late interval step not one LSB");
  AST_SAT_TOP: assert property (!off0 && q.ch[0].tgt != 13'h0000 && q.ch[0].gain == 12'hfff |=> q.ch[0].gain >= 12'hff0)
    else $error("gain wrapped at full scale");
  AST_P1_STEP: assert property (q.ch[0].ph == PH_ONE && !off0 && d.ch[0].gain > q.ch[0].gain
    && d.ch[0].gain != 12'hfff |-> d.ch[0].gain - q.ch[0].gain == {8'h00, 4'h1 << step0[7:6]})
    else $error("first interval step size wrong");
endmodule // opl_loop_top

// >>> common/opl_pkg.sv
package opl_pkg;
  localparam int unsigned NCH = 3;
  localparam int unsigned LOOP_DIV = 3;
  localparam int unsigned TIMING_PRESCALE = 16;
  localparam logic [7:0] REG_RESET = 8'h00;

  localparam logic [7:0] IDX_LOOP_GLOBAL_CONTROL = 8'h29;
  localparam logic [7:0] IDX_GAIN_TARGET_HI_A = 8'h2a;
  localparam logic [7:0] IDX_GAIN_TARGET_LO_A = 8'h2b;
  localparam logic [7:0] IDX_OFFSET_TARGET_HI_A = 8'h2c;
  localparam logic [7:0] IDX_OFFSET_TARGET_LO_A = 8'h2d;
  localparam logic [7:0] IDX_GAIN_TARGET_HI_B = 8'h2e;
  localparam logic [7:0] IDX_GAIN_TARGET_LO_B = 8'h2f;
  localparam logic [7:0] IDX_OFFSET_TARGET_HI_B = 8'h30;
  localparam logic [7:0] IDX_OFFSET_TARGET_LO_B = 8'h31;
  localparam logic [7:0] IDX_GAIN_TARGET_HI_C = 8'h32;
  localparam logic [7:0] IDX_GAIN_TARGET_LO_C = 8'h33;
  localparam logic [7:0] IDX_OFFSET_TARGET_HI_C = 8'h34;
  localparam logic [7:0] IDX_OFFSET_TARGET_LO_C = 8'h35;
  localparam logic [7:0] IDX_LOOP_INTERVAL_CH2 = 8'h36;
  localparam logic [7:0] IDX_LOOP_STEP_CH2 = 8'h37;
  localparam logic [7:0] IDX_LOOP_SELECT_CH2 = 8'h38;
  localparam logic [7:0] IDX_HOLE_A = 8'h39;
  localparam logic [7:0] IDX_LOOP_INTERVAL_CH1 = 8'h3a;
  localparam logic [7:0] IDX_LOOP_STEP_CH1 = 8'h3b;
  localparam logic [7:0] IDX_LOOP_SELECT_CH1 = 8'h3c;
  localparam logic [7:0] IDX_HOLE_B = 8'h3d;
  localparam logic [7:0] IDX_LOOP_INTERVAL_CH0 = 8'h3e;
  localparam logic [7:0] IDX_LOOP_STEP_CH0 = 8'h3f;
  localparam logic [7:0] IDX_LOOP_SELECT_CH0 = 8'h40;
  localparam logic [7:0] IDX_DRIVE_GAIN_HI_CH0 = 8'h41;
  localparam logic [7:0] IDX_DRIVE_GAIN_LO_CH0 = 8'h42;
  localparam logic [7:0] IDX_DRIVE_GAIN_HI_CH1 = 8'h43;
  localparam logic [7:0] IDX_DRIVE_GAIN_LO_CH1 = 8'h44;
  localparam logic [7:0] IDX_DRIVE_GAIN_HI_CH2 = 8'h45;
  localparam logic [7:0] IDX_DRIVE_GAIN_LO_CH2 = 8'h46;
  localparam logic [7:0] IDX_CLOCK_SOURCE = 8'h47;
  localparam logic [7:0] IDX_OSC_CONTROL = 8'h48;
  localparam logic [7:0] IDX_CLK_DIVIDER = 8'h49;
  localparam logic [7:0] IDX_TIA_FILTER = 8'h4a;
  localparam logic [7:0] IDX_STATUS_CH0 = 8'h50;
  localparam logic [7:0] IDX_FIRST = IDX_LOOP_GLOBAL_CONTROL;
  localparam logic [7:0] IDX_LAST = IDX_TIA_FILTER;
  localparam int unsigned NREG = 34;

  localparam logic [NCH-1:0][7:0] IDX_TGT_HI = {IDX_GAIN_TARGET_HI_C, IDX_GAIN_TARGET_HI_B, IDX_GAIN_TARGET_HI_A};
  localparam logic [NCH-1:0][7:0] IDX_TGT_LO = {IDX_GAIN_TARGET_LO_C, IDX_GAIN_TARGET_LO_B, IDX_GAIN_TARGET_LO_A};
  localparam logic [NCH-1:0][7:0] IDX_INTV = {IDX_LOOP_INTERVAL_CH2, IDX_LOOP_INTERVAL_CH1, IDX_LOOP_INTERVAL_CH0};
  localparam logic [NCH-1:0][7:0] IDX_STEP = {IDX_LOOP_STEP_CH2, IDX_LOOP_STEP_CH1, IDX_LOOP_STEP_CH0};
  localparam logic [NCH-1:0][7:0] IDX_SEL = {IDX_LOOP_SELECT_CH2, IDX_LOOP_SELECT_CH1, IDX_LOOP_SELECT_CH0};
  localparam logic [NCH-1:0][7:0] IDX_MAN_HI = {IDX_DRIVE_GAIN_HI_CH2, IDX_DRIVE_GAIN_HI_CH1, IDX_DRIVE_GAIN_HI_CH0};
  localparam logic [NCH-1:0][7:0] IDX_MAN_LO = {IDX_DRIVE_GAIN_LO_CH2, IDX_DRIVE_GAIN_LO_CH1, IDX_DRIVE_GAIN_LO_CH0};

  localparam int unsigned SEL_PD_LSB = 1;
  localparam int unsigned SEL_DEC_LSB = 5;
  localparam int unsigned STEP1_LSB = 6;
  localparam int unsigned STEP2_LSB = 4;
  localparam int unsigned DIVF_LSB = 0;
  localparam int unsigned LEN1_LSB = 6;
  localparam int unsigned LEN2_LSB = 4;
  localparam int unsigned LEN3_LSB = 2;
  localparam int unsigned DSTART_LSB = 0;
  localparam int unsigned TDIV_LSB = 4;
  localparam int unsigned EXT_CLK_BIT = 3;
  localparam logic [1:0] PD_OFF = 2'b11;

  localparam logic [3:0][7:0] LEN1_TAB = {8'hff, 8'h3f, 8'h0f, 8'h00};
  localparam logic [3:0][7:0] LEN23_TAB = {8'h7f, 8'h3f, 8'h1f, 8'h00};
  localparam logic [3:0][3:0] DIVF_TAB = {4'hf, 4'h3, 4'h1, 4'h0};
  localparam logic [3:0][7:0] DSTART_TAB = {8'hc0, 8'h80, 8'h40, 8'h00};
  localparam logic [7:0][10:0] TDIV_TAB = {11'h7ff, 11'h3ff, 11'h1ff, 11'h0ff, 11'h00f, 11'h003, 11'h001, 11'h000};

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    PH_IDLE  = 3'b000,
    PH_ONE   = 3'b001,
    PH_TWO   = 3'b011,
    PH_THREE = 3'b010,
    PH_FOUR  = 3'b110
  } opl_phase_e;
endpackage

// >>> src/opl_sync.sv
`timescale 1ns/10ps
module opl_sync #(
  parameter int unsigned W = 1
)(
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } opl_sync_s;

  opl_sync_s q;
  opl_sync_s d;

  if (W < 1) begin : g_chk
    $error("opl_sync: W must be at least 1");
  end

  always_comb begin
    d = q;
    d.s1 = async_in;
    d.s2 = q.s1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) q <= '0;
    else q <= d;
  end

  assign sync_out = q.s2;
endmodule // opl_sync

// >>> src/opl_tick_div.sv
`timescale 1ns/10ps
module opl_tick_div #(
  parameter int unsigned W = 4
)(
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         in_tick,
  input  wire logic [W-1:0] limit,
  output logic              tick
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } opl_div_s;

  opl_div_s q;
  opl_div_s d;

  if (W < 1) begin : g_chk
    $error("opl_tick_div: W must be at least 1");
  end

  // Compare with >= so a lowered limit never strands the counter
  assign tick = in_tick && (q.cnt >= limit);

  always_comb begin
    d = q;
    if (in_tick) d.cnt = tick ? '0 : q.cnt + 1'b1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) q <= '0;
    else q <= d;
  end
endmodule // opl_tick_div

// >>> bench/opl_sense_model.sv
`timescale 1ns/10ps
module opl_sense_model
  import opl_pkg::*;
(
  input  wire logic [NCH-1:0][11:0] channel_drive_current,
  input  wire logic [NCH-1:0][12:0] target_code,
  output logic      [NCH-1:0]       sense_below,
  output logic      [NCH-1:0]       sense_above
);
  // Ideal comparator: sense input i watches channel i, one drive LSB per target code
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      sense_below[i] = {1'b0, channel_drive_current[i]} < target_code[i];
      sense_above[i] = {1'b0, channel_drive_current[i]} > target_code[i];
    end
  end
endmodule // opl_sense_model

// >>> bench/testbench.sv
`timescale 1ns/10ps
module testbench
  import opl_pkg::*;
;
  logic                 aclk = 1'b0;
  logic                 aresetn = 1'b0;
  logic [11:0]          awaddr = 12'h000;
  logic [11:0]          araddr = 12'h000;
  logic [31:0]          wdata = 32'h0;
  logic                 awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [NCH-1:0]       con = 3'h0;
  logic                 awready, wready, bvalid, arready, rvalid, tick, ext;
  logic [1:0]           bresp, rresp, tia, csel;
  logic [31:0]          rdata;
  logic [3:0]           osc;
  logic [NCH-1:0]       below, above;
  logic [NCH-1:0][11:0] drv;
  logic [NCH-1:0][12:0] tgt;
  int                   n_mismatch = 0;
  int                   checks_done = 0;
  // Row: [25:24] response, [23:16] index, [15:8] written, [7:0] read back
  localparam logic [31:0] ROWS [14] = '{32'h0029e8e8, 32'h002a0101, 32'h002b9090, 32'h00470303,
    32'h00480808, 32'h004a0202, 32'h00491010, 32'h02395a00, 32'h00380606, 32'h00450a0a,
    32'h0046bcbc, 32'h003e5454, 32'h003fd0d0, 32'h00400000};

  always #2.5 aclk = ~aclk;

  opl_loop_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .color_on_input(con), .sense_below(below), .sense_above(above),
    .channel_drive_current(drv), .target_code(tgt), .tia_filter_select(tia),
    .clock_source_select(csel), .osc_control(osc), .ext_timing_clock_en(ext), .timing_tick(tick));

  opl_sense_model u_sense (.channel_drive_current(drv), .target_code(tgt), .sense_below(below),
    .sense_above(above));

  task automatic results();
    $display("Checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask

  // Valid held until its own ready is seen at an edge
  task automatic wr(input logic [7:0] idx, input logic [7:0] v, output logic [1:0] r);
    logic a, w, b;
    @(posedge aclk);
    awaddr <= {2'b00, idx, 2'b00};
    wdata <= {24'h0, v};
    {awvalid, wvalid, bready} <= 3'b111;
    for (int n = 0; n < 60; n++) begin
      @(negedge aclk);
      {a, w, b, r} = {awvalid & awready, wvalid & wready, bvalid, bresp};
      @(posedge aclk);
      if (a) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      if (b) begin
        bready <= 1'b0;
        return;
      end
    end
    n_mismatch++;
    results();
  endtask

  task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
    logic a, b;
    @(posedge aclk);
    araddr <= {2'b00, idx, 2'b00};
    {arvalid, rready} <= 2'b11;
    for (int n = 0; n < 60; n++) begin
      @(negedge aclk);
      {a, b, d, r} = {arvalid & arready, rvalid, rdata, rresp};
      @(posedge aclk);
      if (a) arvalid <= 1'b0;
      if (b) begin
        rready <= 1'b0;
        return;
      end
    end
    n_mismatch++;
    results();
  endtask

  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [11:0] g;
    int          k;
    repeat (20) @(posedge aclk);
    chk("awready", awready, 1);
    chk("drive0", drv[0], 0);
    aresetn <= 1'b1;
    $display("Reset test done");
    foreach (ROWS[i]) begin
      wr(ROWS[i][23:16], ROWS[i][15:8], r);
      chk("bresp", r, ROWS[i][25:24]);
      rd(ROWS[i][23:16], d, r);
      chk("rresp", r, ROWS[i][25:24]);
      chk("rdata", d, ROWS[i][7:0]);
    end
    chk("ext_clk", ext, 1);
    chk("clk_src", csel, 2'h3);
    chk("osc", osc, 4'h8);
    chk("tia", tia, 2'h2);
    chk("manual", drv[2], 12'habc);
    k = 0;
    repeat (320) begin
      @(negedge aclk);
      k += tick;
    end
    chk("ticks", k, 10);
    $display("Register test done");
    @(posedge aclk);
    con[0] <= 1'b1;
    repeat (10) @(posedge aclk);
    chk("target", tgt[0], 13'h190);
    // Three cycles always span exactly one loop tick
    repeat (17) @(posedge aclk);
    g = drv[0];
    repeat (3) @(posedge aclk);
    chk("step1", drv[0] - g, 8);
    repeat (67) @(posedge aclk);
    g = drv[0];
    repeat (3) @(posedge aclk);
    chk("step2", drv[0] - g, 2);
    repeat (1500) @(posedge aclk);
    chk("settle", drv[0] > 396 && drv[0] < 404, 1);
    rd(IDX_STATUS_CH0, d, r);
    chk("phase", d[14:12], PH_FOUR);
    $display("Loop test done");
    // Second color first, so the new rise of channel 0 meets an already frozen loop
    con[1] <= 1'b1;
    repeat (50) @(posedge aclk);
    con[0] <= 1'b0;
    wr(IDX_GAIN_TARGET_HI_A, 8'h03, r);
    wr(IDX_GAIN_TARGET_LO_A, 8'h00, r);
    repeat (50) @(posedge aclk);
    con[0] <= 1'b1;
    repeat (10) @(posedge aclk);
    g = drv[0];
    repeat (100) @(posedge aclk);
    chk("frozen", drv[0], g);
    con[1] <= 1'b0;
    repeat (300) @(posedge aclk);
    chk("resumed", drv[0] > g, 1);
    con[0] <= 1'b0;
    wr(IDX_GAIN_TARGET_HI_A, 8'h1f, r);
    wr(IDX_GAIN_TARGET_LO_A, 8'hff, r);
    repeat (50) @(posedge aclk);
    con[0] <= 1'b1;
    repeat (12000) @(posedge aclk);
    chk("full", drv[0], 12'hfff);
    repeat (30) @(posedge aclk);
    chk("no_wrap", drv[0], 12'hfff);
    $display("Freeze and limit test done");
    wr(IDX_DRIVE_GAIN_HI_CH0, 8'h05, r);
    wr(IDX_DRIVE_GAIN_LO_CH0, 8'h5a, r);
    wr(IDX_LOOP_SELECT_CH0, 8'h06, r);
    repeat (5) @(posedge aclk);
    chk("manual0", drv[0], 12'h55a);
    con[0] <= 1'b0;
    // Divide by four and pairs of mismatches: one LSB every eight loop ticks
    wr(IDX_LOOP_SELECT_CH0, 8'h20, r);
    wr(IDX_LOOP_STEP_CH0, 8'h02, r);
    wr(IDX_LOOP_INTERVAL_CH0, 8'h00, r);
    con[0] <= 1'b1;
    repeat (30) @(posedge aclk);
    g = drv[0];
    repeat (240) @(posedge aclk);
    chk("decimate", drv[0] - g, 10);
    $display("Manual and decimation test done");
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(IDX_LOOP_GLOBAL_CONTROL, d, r);
    chk("reset_reg", d, 0);
    chk("reset_drive", drv[0], 0);
    $display("Mid-run reset test done");
    results();
  end
endmodule // testbench
